// ==== rtl/dts_pkg.sv ====
/*
 * Constants of the dual timer block: register indices, field positions,
 * reset values, mode codes and bus answers.
 * Assumes a 32-bit AXI4-Lite bus with 12 address bits; byte address is
 * four times the register index.
 */
// Notes on behaviour
// - Timer 0 mode 3 splits into two bytes.
// - Split low byte uses Timer 0 controls.
// - Split low byte counts clock or pin.
// - Split high byte is timer only.
// - Split high byte runs on Timer 1 run.
// - Split high byte overflow sets Timer 1 flag.
// - Timer 1 mode 3 stops Timer 1.
// - Under split, Timer 1 no pin, no flag.
// - Timer 1 overflow still gives rate tick.
// - Under split, mode field runs Timer 1.
// - Under split, mode 3 stops Timer 1.
// - Run needs run bit and gate pass.
// - Counter mode counts pin falling edges.
// - Mode 0 wraps at 13 bits, sets flag.
// - Mode 2 reloads low from high byte.
package dts_pkg;
	localparam int unsigned AW = 12;
	// Register indices; byte address is index times four.
	localparam logic [9:0] IDX_TCS  = 10'h088;
	localparam logic [9:0] IDX_TMC  = 10'h089;
	localparam logic [9:0] IDX_T0L  = 10'h08A;
	localparam logic [9:0] IDX_T0H  = 10'h08B;
	localparam logic [9:0] IDX_T1L  = 10'h08C;
	localparam logic [9:0] IDX_T1H  = 10'h08D;
	localparam logic [9:0] IDX_CLK  = 10'h08E;
	localparam logic [9:0] IDX_ISTS = 10'h090;
	localparam logic [9:0] IDX_IMSK = 10'h091;
	// Control/status fields.
	localparam int B_TF1 = 7;
	localparam int B_TR1 = 6;
	localparam int B_TF0 = 5;
	localparam int B_TR0 = 4;
	localparam int B_IE1 = 3;
	localparam int B_IT1 = 2;
	localparam int B_IE0 = 1;
	localparam int B_IT0 = 0;
	// Mode configuration fields.
	localparam int B_T1_GATE_ENABLE = 7;
	localparam int B_CT1   = 6;
	localparam int B_T0_GATE_ENABLE = 3;
	localparam int B_CT0   = 2;
	// Clock select fields: one selects the system clock, zero the prescaled tick.
	localparam int B_T0SYS = 0;
	localparam int B_T1SYS = 1;
	// Interrupt status fields.
	localparam int I_TF0  = 0;
	localparam int I_TF1  = 1;
	localparam int I_TICK = 2;
	localparam logic [1:0] MODE_13 = 2'h0;
	localparam logic [1:0] MODE_16 = 2'h1;
	localparam logic [1:0] MODE_8R = 2'h2;
	localparam logic [1:0] MODE_SP = 2'h3;
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [1:0] RESP_OK  = 2'h0;
	localparam logic [1:0] RESP_ERR = 2'h2;
endpackage

// ==== rtl/dts_timer.sv ====
/*
 * Two 8051-style counter/timers with split mode, behind an AXI4-Lite slave.
 * Assumes event and gate pins are asynchronous, presc_tick is a one-cycle
 * pulse from logic on mclk, and vector acknowledges are one-cycle pulses.
 */
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/1ns
`default_nettype none
module dts_timer (
	input  wire logic                 mclk,
	input  wire logic                 rst,
	input  wire logic [dts_pkg::AW-1:0] s_axi_awaddr,
	input  wire logic                 s_axi_awvalid,
	output logic                      s_axi_awready,
	input  wire logic [31:0]          s_axi_wdata,
	input  wire logic [3:0]           s_axi_wstrb,
	input  wire logic                 s_axi_wvalid,
	output logic                      s_axi_wready,
	output logic [1:0]                s_axi_bresp,
	output logic                      s_axi_bvalid,
	input  wire logic                 s_axi_bready,
	input  wire logic [dts_pkg::AW-1:0] s_axi_araddr,
	input  wire logic                 s_axi_arvalid,
	output logic                      s_axi_arready,
	output logic [31:0]               s_axi_rdata,
	output logic [1:0]                s_axi_rresp,
	output logic                      s_axi_rvalid,
	input  wire logic                 s_axi_rready,
	input  wire logic                 t0_pin,
	input  wire logic                 t1_pin,
	input  wire logic                 ext_irq0_n,
	input  wire logic                 ext_irq1_n,
	input  wire logic                 presc_tick,
	input  wire logic                 t0_vec_ack,
	input  wire logic                 t1_vec_ack,
	input  wire logic                 ext0_vec_ack,
	input  wire logic                 ext1_vec_ack,
	output logic                      t0_overflow_flag,
	output logic                      t1_overflow_flag,
	output logic                      t1_rate_tick,
	output logic                      irq
);
	import dts_pkg::*;

	function automatic logic [16:0] dts_step(input logic [1:0] m, input logic [7:0] lo, input logic [7:0] hi);
		logic [13:0] c13;
		logic [16:0] c16;
		logic [8:0]  c8;
		c13 = {1'b0, hi, lo[4:0]} + 14'h0001;
		c16 = {1'b0, hi, lo} + 17'h00001;
		c8  = {1'b0, lo} + 9'h001;
		case (m)
			MODE_13: dts_step = {c13[13], c13[12:5], lo[7:5], c13[4:0]};
			MODE_16: dts_step = c16;
			MODE_8R: dts_step = c8[8] ? {1'b1, hi, hi} : {1'b0, hi, c8[7:0]};
			default: dts_step = {1'b0, hi, lo};
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers: stage 1 feeds only stage 2.
	logic [3:0] pin_s1_r;
	logic [3:0] pin_s2_r;
	logic [3:0] pin_s3_r;
	logic [3:0] pin_fall;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			pin_s1_r <= 4'hF;
			pin_s2_r <= 4'hF;
			pin_s3_r <= 4'hF;
		end else begin
			pin_s1_r <= {ext_irq1_n, ext_irq0_n, t1_pin, t0_pin};
			pin_s2_r <= pin_s1_r;
			pin_s3_r <= pin_s2_r;
		end
	end
	assign pin_fall = pin_s3_r & ~pin_s2_r;

	////////////////////////////////////////////////////////////////////////
	// Bus slave state.
	logic            aw_have_r, aw_have_nxt, w_have_r, w_have_nxt;
	logic [9:0]      aw_idx_r, aw_idx_nxt;
	logic [7:0]      w_byte_r, w_byte_nxt;
	logic            w_lane_r, w_lane_nxt;
	logic            awready_r, awready_nxt, wready_r, wready_nxt;
	logic            bvalid_r, bvalid_nxt, arready_r, arready_nxt, rvalid_r, rvalid_nxt;
	logic [1:0]      bresp_r, bresp_nxt, rresp_r, rresp_nxt;
	logic [31:0]     rdata_r, rdata_nxt;
	logic            wr_go;
	logic [9:0]      ar_idx;

	// Timer state.
	logic [7:0] tcs_r, tcs_nxt, tmc_r, tmc_nxt, clk_r, clk_nxt;
	logic [7:0] t0l_r, t0l_nxt, t0h_r, t0h_nxt, t1l_r, t1l_nxt, t1h_r, t1h_nxt;
	logic [2:0] ists_r, ists_nxt, imsk_r, imsk_nxt;
	logic       irq_r, irq_nxt, tick_r, tick_nxt;

	function automatic logic wr_hit(input logic go, input logic lane, input logic [9:0] a, input logic [9:0] r);
		wr_hit = go && lane && (a == r);
	endfunction

	always_comb begin
		aw_have_nxt = aw_have_r;
		w_have_nxt  = w_have_r;
		aw_idx_nxt  = aw_idx_r;
		w_byte_nxt  = w_byte_r;
		w_lane_nxt  = w_lane_r;
		bvalid_nxt  = bvalid_r;
		bresp_nxt   = bresp_r;
		arready_nxt = arready_r;
		rvalid_nxt  = rvalid_r;
		rresp_nxt   = rresp_r;
		rdata_nxt   = rdata_r;
		ar_idx      = s_axi_araddr[AW-1:2];
		if (s_axi_awvalid && awready_r) begin
			aw_have_nxt = 1'b1;
			aw_idx_nxt  = s_axi_awaddr[AW-1:2];
		end
		if (s_axi_wvalid && wready_r) begin
			w_have_nxt = 1'b1;
			w_byte_nxt = s_axi_wdata[7:0];
			w_lane_nxt = s_axi_wstrb[0];
		end
		wr_go = aw_have_r && w_have_r && !bvalid_r;
		if (wr_go) begin
			aw_have_nxt = 1'b0;
			w_have_nxt  = 1'b0;
			bvalid_nxt  = 1'b1;
			bresp_nxt   = RESP_OK;
			case (aw_idx_r)
				IDX_TCS, IDX_TMC, IDX_T0L, IDX_T0H, IDX_T1L, IDX_T1H, IDX_CLK, IDX_ISTS, IDX_IMSK: bresp_nxt = RESP_OK;
				default: bresp_nxt = RESP_ERR;
			endcase
		end
		if (bvalid_r && s_axi_bready) begin
			bvalid_nxt = 1'b0;
		end
		awready_nxt = !aw_have_nxt && !bvalid_nxt;
		wready_nxt  = !w_have_nxt && !bvalid_nxt;
		if (s_axi_arvalid && arready_r) begin
			arready_nxt = 1'b0;
			rvalid_nxt  = 1'b1;
			rresp_nxt   = RESP_OK;
			rdata_nxt   = 32'h00000000;
			case (ar_idx)
				IDX_TCS:  rdata_nxt[7:0] = tcs_r;
				IDX_TMC:  rdata_nxt[7:0] = tmc_r;
				IDX_T0L:  rdata_nxt[7:0] = t0l_r;
				IDX_T0H:  rdata_nxt[7:0] = t0h_r;
				IDX_T1L:  rdata_nxt[7:0] = t1l_r;
				IDX_T1H:  rdata_nxt[7:0] = t1h_r;
				IDX_CLK:  rdata_nxt[1:0] = clk_r[1:0];
				IDX_ISTS: rdata_nxt[2:0] = ists_r;
				IDX_IMSK: rdata_nxt[2:0] = imsk_r;
				default:  rresp_nxt = RESP_ERR;
			endcase
		end else if (rvalid_r && s_axi_rready) begin
			rvalid_nxt  = 1'b0;
			arready_nxt = 1'b1;
		end
		// An idle read side offers its address slot again, also on the first edge after reset.
		if (!rvalid_r && !(s_axi_arvalid && arready_r)) begin
			arready_nxt = 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Timer datapath. A software byte write in the same cycle as a count
	// wins for that byte, so a freshly loaded value is never skipped.
	logic        split, t0_gate_enable_ok, t1_gate_enable_ok, run0, run0h, run1, en0, en0h, en1;
	logic        src0, src1, ovf0, ovf0h, ovf1;
	logic [16:0] st0, st1;
	logic [8:0]  c0l, c0h;

	always_comb begin
		tcs_nxt = tcs_r;
		tmc_nxt = tmc_r;
		clk_nxt = clk_r;
		t0l_nxt = t0l_r;
		t0h_nxt = t0h_r;
		t1l_nxt = t1l_r;
		t1h_nxt = t1h_r;
		imsk_nxt = imsk_r;
		ists_nxt = ists_r;
		split = (tmc_r[1:0] == MODE_SP);
		t0_gate_enable_ok = !tmc_r[B_T0_GATE_ENABLE] || pin_s2_r[2];
		t1_gate_enable_ok = !tmc_r[B_T1_GATE_ENABLE] || pin_s2_r[3];
		run0 = tcs_r[B_TR0] && t0_gate_enable_ok;
		run0h = split && tcs_r[B_TR1];
		run1 = (tmc_r[5:4] != MODE_SP) && (split || (tcs_r[B_TR1] && t1_gate_enable_ok));
		src0 = tmc_r[B_CT0] ? pin_fall[0] : (clk_r[B_T0SYS] || presc_tick);
		src1 = (tmc_r[B_CT1] && !split) ? pin_fall[1] : (clk_r[B_T1SYS] || presc_tick);
		en0  = run0 && src0;
		en0h = run0h && (clk_r[B_T0SYS] || presc_tick);
		en1  = run1 && src1;
		st0 = dts_step(tmc_r[1:0], t0l_r, t0h_r);
		st1 = dts_step(tmc_r[5:4], t1l_r, t1h_r);
		c0l = {1'b0, t0l_r} + 9'h001;
		c0h = {1'b0, t0h_r} + 9'h001;
		ovf0 = 1'b0;
		ovf0h = 1'b0;
		ovf1 = 1'b0;
		if (split) begin
			if (en0) begin
				t0l_nxt = c0l[7:0];
				ovf0 = c0l[8];
			end
			if (en0h) begin
				t0h_nxt = c0h[7:0];
				ovf0h = c0h[8];
			end
		end else if (en0) begin
			{ovf0, t0h_nxt, t0l_nxt} = st0;
		end
		if (en1) begin
			{ovf1, t1h_nxt, t1l_nxt} = st1;
		end
		if (wr_hit(wr_go, w_lane_r, aw_idx_r, IDX_TMC)) tmc_nxt = w_byte_r;
		if (wr_hit(wr_go, w_lane_r, aw_idx_r, IDX_CLK)) clk_nxt = {6'h00, w_byte_r[1:0]};
		if (wr_hit(wr_go, w_lane_r, aw_idx_r, IDX_T0L)) t0l_nxt = w_byte_r;
		if (wr_hit(wr_go, w_lane_r, aw_idx_r, IDX_T0H)) t0h_nxt = w_byte_r;
		if (wr_hit(wr_go, w_lane_r, aw_idx_r, IDX_T1L)) t1l_nxt = w_byte_r;
		if (wr_hit(wr_go, w_lane_r, aw_idx_r, IDX_T1H)) t1h_nxt = w_byte_r;
		if (wr_hit(wr_go, w_lane_r, aw_idx_r, IDX_IMSK)) imsk_nxt = w_byte_r[2:0];
		if (wr_hit(wr_go, w_lane_r, aw_idx_r, IDX_TCS)) tcs_nxt = w_byte_r;
		if (wr_hit(wr_go, w_lane_r, aw_idx_r, IDX_ISTS)) ists_nxt = ists_r & ~w_byte_r[2:0];
		if (t0_vec_ack) tcs_nxt[B_TF0] = 1'b0;
		if (t1_vec_ack) tcs_nxt[B_TF1] = 1'b0;
		if (ext0_vec_ack) tcs_nxt[B_IE0] = 1'b0;
		if (ext1_vec_ack) tcs_nxt[B_IE1] = 1'b0;
		// Hardware sets come last so an event in a clearing cycle survives.
		if (ovf0) tcs_nxt[B_TF0] = 1'b1;
		if (split ? ovf0h : ovf1) tcs_nxt[B_TF1] = 1'b1;
		if (tcs_r[B_IT0] ? pin_fall[2] : !pin_s2_r[2]) tcs_nxt[B_IE0] = 1'b1;
		if (tcs_r[B_IT1] ? pin_fall[3] : !pin_s2_r[3]) tcs_nxt[B_IE1] = 1'b1;
		// Level mode flags track the pin rather than latch.
		if (!tcs_r[B_IT0] && pin_s2_r[2]) tcs_nxt[B_IE0] = 1'b0;
		if (!tcs_r[B_IT1] && pin_s2_r[3]) tcs_nxt[B_IE1] = 1'b0;
		if (ovf0) ists_nxt[I_TF0] = 1'b1;
		if (split ? ovf0h : ovf1) ists_nxt[I_TF1] = 1'b1;
		tick_nxt = ovf1;
		if (ovf1) ists_nxt[I_TICK] = 1'b1;
		irq_nxt = |(ists_nxt & imsk_nxt);
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			aw_have_r <= 1'b0;
			w_have_r  <= 1'b0;
			aw_idx_r  <= 10'h000;
			w_byte_r  <= RST_BYTE;
			w_lane_r  <= 1'b0;
			awready_r <= 1'b0;
			wready_r  <= 1'b0;
			bvalid_r  <= 1'b0;
			bresp_r   <= RESP_OK;
			arready_r <= 1'b0;
			rvalid_r  <= 1'b0;
			rresp_r   <= RESP_OK;
			rdata_r   <= 32'h00000000;
			tcs_r     <= RST_BYTE;
			tmc_r     <= RST_BYTE;
			clk_r     <= RST_BYTE;
			t0l_r     <= RST_BYTE;
			t0h_r     <= RST_BYTE;
			t1l_r     <= RST_BYTE;
			t1h_r     <= RST_BYTE;
			ists_r    <= 3'h0;
			imsk_r    <= 3'h0;
			irq_r     <= 1'b0;
			tick_r    <= 1'b0;
		end else begin
			aw_have_r <= aw_have_nxt;
			w_have_r  <= w_have_nxt;
			aw_idx_r  <= aw_idx_nxt;
			w_byte_r  <= w_byte_nxt;
			w_lane_r  <= w_lane_nxt;
			awready_r <= awready_nxt;
			wready_r  <= wready_nxt;
			bvalid_r  <= bvalid_nxt;
			bresp_r   <= bresp_nxt;
			arready_r <= arready_nxt;
			rvalid_r  <= rvalid_nxt;
			rresp_r   <= rresp_nxt;
			rdata_r   <= rdata_nxt;
			tcs_r     <= tcs_nxt;
			tmc_r     <= tmc_nxt;
			clk_r     <= clk_nxt;
			t0l_r     <= t0l_nxt;
			t0h_r     <= t0h_nxt;
			t1l_r     <= t1l_nxt;
			t1h_r     <= t1h_nxt;
			ists_r    <= ists_nxt;
			imsk_r    <= imsk_nxt;
			irq_r     <= irq_nxt;
			tick_r    <= tick_nxt;
		end
	end

	assign s_axi_awready    = awready_r;
	assign s_axi_wready     = wready_r;
	assign s_axi_bvalid     = bvalid_r;
	assign s_axi_bresp      = bresp_r;
	assign s_axi_arready    = arready_r;
	assign s_axi_rvalid     = rvalid_r;
	assign s_axi_rresp      = rresp_r;
	assign s_axi_rdata      = rdata_r;
	assign t0_overflow_flag = tcs_r[B_TF0];
	assign t1_overflow_flag = tcs_r[B_TF1];
	assign t1_rate_tick     = tick_r;
	assign irq              = irq_r;
endmodule
`default_nettype wire

// ==== sim/dts_timer_properties.sv ====
/*
 * Bus handshake properties of the dual timer block.
 * Assumes it is bound to every dts_timer instance and sees only its ports.
 */
`timescale 1ns/1ns
`default_nettype none
module dts_timer_properties (
	input wire logic        mclk,
	input wire logic        rst,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready
);
	import dts_pkg::*;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer dropped early");
	rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)
		&& $stable(s_axi_rresp)) else $error("read answer changed early");
	write_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while answer pending");
	read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken while answer pending");
	write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("write answer not two cycles on");
	read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer not one cycle on");
	addr_taken_a: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
		else $error("address ready while one held");
	read_gap_a: assert property (s_axi_arvalid && s_axi_arready |=> !s_axi_arready ##1
		(s_axi_arready == !s_axi_rvalid)) else $error("read address ready too soon");
	read_release_a: assert property (s_axi_rvalid && s_axi_rready |=> s_axi_arready && !s_axi_rvalid)
		else $error("read side not released after answer");
	write_release_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready
		&& s_axi_wready) else $error("write side not released after answer");
	resp_code_a: assert property (s_axi_bvalid |-> s_axi_bresp == RESP_OK || s_axi_bresp == RESP_ERR)
		else $error("bad write response code");
endmodule
bind dts_timer dts_timer_properties dts_timer_properties_inst (.mclk(mclk), .rst(rst),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready));
`default_nettype wire

// ==== sim/dts_pins.sv ====
/*
 * Event pin model: emits a loaded number of falling edges and a prescaler tick.
 * Assumes the bench pulses load for one cycle on mclk.
 */
`timescale 1ns/1ns
`default_nettype none
module dts_pins (
	input  wire logic       mclk,
	input  wire logic       rst,
	input  wire logic       load,
	input  wire logic [7:0] num,
	output logic            t0_pin,
	output logic            presc_tick
);
	logic [7:0] left_r;
	logic [1:0] ph_r;
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			left_r <= 8'h00;
			ph_r   <= 2'h0;
		end else begin
			// A burst restarts the phase so every low and high level lasts two cycles.
			ph_r <= load ? 2'h0 : ph_r + 2'h1;
			if (load)
				left_r <= num;
			else if (ph_r == 2'h1 && left_r != 8'h00)
				left_r <= left_r - 8'h01;
		end
	end
	// The pin idles high, as its pull-up would hold it between bursts.
	assign t0_pin     = !(left_r != 8'h00 && !ph_r[1]);
	assign presc_tick = (ph_r == 2'h0);
endmodule
`default_nettype wire

// ==== sim/dual_timer_split_mode_tb.sv ====
/*
 * Self-checking bench of the dual timer: bus, modes, gate, split mode.
 * Assumes dts_pins supplies the event pin and the prescaler tick.
 */
`timescale 1ns/1ns
`default_nettype none
module dual_timer_split_mode_tb;
	import dts_pkg::*;
	logic        mclk, rst, awv, wv, bre, arv, rre, g0, ld, awr, wrd, bv, arr, rv, f0, f1, tick, irq, pin, pt;
	logic [11:0] awa, ara;
	logic [31:0] wd, rdat, got, seed, lag;
	logic [1:0]  bresp, rresp, resp, ack;
	logic [7:0]  num, e;
	int          mismatches, checks, ticks, t_snap, i;
	always #50 mclk = ~mclk;
	always @(posedge mclk) if (tick) ticks <= ticks + 1;
	dts_timer dts_timer_inst (.mclk(mclk), .rst(rst), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
		.s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wrd),
		.s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_araddr(ara), .s_axi_arvalid(arv),
		.s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rre),
		.t0_pin(pin), .t1_pin(1'b1), .ext_irq0_n(g0), .ext_irq1_n(1'b1), .presc_tick(pt),
		.t0_vec_ack(ack[0]), .t1_vec_ack(ack[1]), .ext0_vec_ack(1'b0), .ext1_vec_ack(1'b0),
		.t0_overflow_flag(f0), .t1_overflow_flag(f1), .t1_rate_tick(tick), .irq(irq));
	dts_pins dts_pins_inst (.mclk(mclk), .rst(rst), .load(ld), .num(num), .t0_pin(pin), .presc_tick(pt));
	////////////////////////////////////////////////////////////
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction
	function automatic logic [31:0] reload_n(input logic [7:0] lo, input logic [7:0] hi, input int n);
		for (int j = 0; j < n; j++)
			lo = (lo == 8'hFF) ? hi : lo + 8'h01;
		return {24'h0, lo};
	endfunction
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		checks++;
		if (g !== x) begin
			mismatches++;
			$display("MISMATCH t=%0t got %h exp %h", $time, g, x);
		end
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge mclk);
	endtask
	task automatic wr(input logic [9:0] idx, input logic [7:0] v);
		int n;
		lag = xs(lag);
		@(posedge mclk);
		awa <= {idx, 2'b00};
		wd  <= {24'h0, v};
		awv <= 1'b1;
		wv  <= 1'b1;
		// A random late bready makes the slave hold its answer.
		bre <= lag[0];
		for (n = 0; n < 40; n++) begin
			@(posedge mclk);
			if (bv && bre) break;
			if (awr) awv <= 1'b0;
			if (wrd) wv <= 1'b0;
			if (bv) bre <= 1'b1;
		end
		resp = bresp;
		bre <= 1'b0;
		if (n == 40) chk(0, 1);
		// The interrupt output is registered on the same edge as the commit; idle two cycles before the next access.
		idle(2);
	endtask
	task automatic rd(input logic [9:0] idx);
		int n;
		lag = xs(lag);
		@(posedge mclk);
		ara <= {idx, 2'b00};
		arv <= 1'b1;
		rre <= lag[1];
		for (n = 0; n < 40; n++) begin
			@(posedge mclk);
			if (rv && rre) break;
			if (arr) arv <= 1'b0;
			if (rv) rre <= 1'b1;
		end
		got = rdat;
		resp = rresp;
		rre <= 1'b0;
		if (n == 40) chk(0, 1);
	endtask
	task automatic emit(input logic [7:0] k);
		@(posedge mclk);
		num <= k;
		ld  <= 1'b1;
		@(posedge mclk);
		ld <= 1'b0;
		idle(int'(k) * 4 + 10);
	endtask
	task automatic pulse_ack(input logic [1:0] a);
		@(posedge mclk);
		ack <= a;
		@(posedge mclk);
		ack <= 2'b00;
		idle(2);
	endtask
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge mclk);
		mismatches++;
		end_of_test();
	end
	initial begin
		mclk = 0; rst = 1; awv = 0; wv = 0; bre = 0; arv = 0; rre = 0; g0 = 1; ld = 0; ack = 0;
		awa = 0; ara = 0; wd = 0; num = 0; ticks = 0; seed = 32'h21F5; lag = 32'h21F5;
		idle(3);
		rst <= 1'b0;
		idle(2);
		rd(IDX_TMC); chk(got, 32'h0);
		rd(IDX_TCS); chk(got, 32'h0);
		rd(10'h3FF); chk(resp, RESP_ERR);
		wr(10'h3FF, 8'hAA); chk(resp, RESP_ERR);
		for (i = 0; i < 6; i++) begin
			seed = xs(seed);
			e = seed[15:8];
			wr(IDX_T0L + 10'(seed[1:0]), e);
			rd(IDX_T0L + 10'(seed[1:0])); chk(got, {24'h0, e});
		end
		wr(IDX_CLK, 8'h03);
		for (i = 0; i < 2; i++) begin
			wr(IDX_TMC, 8'(i));
			wr(IDX_T0H, 8'hFF);
			wr(IDX_T0L, 8'hFF);
			wr(IDX_TCS, 8'h10);
			idle(8);
			chk(f0, 1);
			wr(IDX_TCS, 8'h20);
			rd(IDX_T0H); chk(got, 32'h0);
			rd(IDX_T0L); chk(got[7:5], i ? 3'h0 : 3'h7);
			chk(irq, 0);
			wr(IDX_IMSK, 8'h01); chk(irq, 1);
			wr(IDX_ISTS, 8'h01); chk(irq, 0);
			wr(IDX_IMSK, 8'h00);
			pulse_ack(2'b01); chk(f0, 0);
		end
		wr(IDX_TMC, 8'h0E);
		wr(IDX_T0H, 8'hF0);
		wr(IDX_T0L, 8'hFE);
		wr(IDX_TCS, 8'h10);
		g0 <= 1'b0;
		emit(3);
		rd(IDX_T0L); chk(got, 32'hFE);
		g0 <= 1'b1;
		emit(3);
		rd(IDX_T0L); chk(got, reload_n(8'hFE, 8'hF0, 3));
		rd(IDX_T0H); chk(got, 32'hF0);
		chk(f0, 1);
		wr(IDX_TCS, 8'h00);
		wr(IDX_TMC, 8'h07);
		wr(IDX_T0H, 8'h10);
		wr(IDX_T0L, 8'h20);
		wr(IDX_TCS, 8'h10);
		emit(2);
		rd(IDX_T0L); chk(got, 32'h22);
		rd(IDX_T0H); chk(got, 32'h10);
		wr(IDX_T0H, 8'hF8);
		wr(IDX_TCS, 8'h40);
		idle(12);
		chk(f1, 1);
		chk(f0, 0);
		wr(IDX_TCS, 8'h80);
		pulse_ack(2'b10); chk(f1, 0);
		wr(IDX_T1H, 8'hFC);
		// Count select set: under split Timer 1 must still run on the clock, the pin is idle.
		wr(IDX_TMC, 8'h63);
		t_snap = ticks;
		// The low byte may start anywhere, so allow a full eight-bit lap.
		idle(300);
		chk(ticks > t_snap, 1);
		chk(f1, 0);
		for (i = 0; i < 2; i++) begin
			wr(IDX_TCS, 8'h40);
			wr(IDX_TMC, i ? 8'h30 : 8'h33);
			rd(IDX_T1L);
			e = got[7:0];
			idle(10);
			rd(IDX_T1L); chk(got, {24'h0, e});
		end
		end_of_test();
	end
endmodule
`default_nettype wire
